// ==== include/agscr_cfg.svh ====
// addresses, field positions, reset values and counts of the gain/status/config slice
`ifndef AGSCR_CFG_SVH
`define AGSCR_CFG_SVH
`define AGSCR_A_GAIN 5'h0B
`define AGSCR_A_STAT 5'h0C
`define AGSCR_A_CFG 5'h0D
`define AGSCR_A_LOCK 5'h1F
`define AGSCR_A_MAP_LO 5'h00
`define AGSCR_A_MAP_HI 5'h1F
`define AGSCR_A_TYPE0_HI 5'h07
`define AGSCR_A_TYPE1_LO 5'h08
`define AGSCR_A_WR_LO 5'h08
`define AGSCR_GROUP_MASK 5'h03
`define AGSCR_GAIN_RST 24'h000000
`define AGSCR_STAT_RST 24'hA90000
`define AGSCR_CFG_RST 24'h386050
`define AGSCR_FLAGS_RST 6'h3F
`define AGSCR_GAIN_WMASK 24'h03FFFF
`define AGSCR_STAT_WMASK 24'hFFF000
`define AGSCR_CFG_WMASK 24'hFFE0FF
`define AGSCR_LOCK_PW 8'hA5
`define AGSCR_LK_CODE 23:16
`define AGSCR_ST_RDPOL 23:22
`define AGSCR_ST_WRINC 21
`define AGSCR_ST_IDLE 20
`define AGSCR_ST_MERGE 19
`define AGSCR_ST_CRCW 18
`define AGSCR_ST_DWIDTH 17:16
`define AGSCR_ST_CRCEN 15
`define AGSCR_ST_MAPINT 14
`define AGSCR_ST_HI 23:6
`define AGSCR_CF_OFFCAL 23
`define AGSCR_CF_GAINCAL 22
`define AGSCR_CF_NOISE_SPREADING_LEVEL 21:20
`define AGSCR_CF_BIAS 19:18
`define AGSCR_CF_PRE 17:16
`define AGSCR_GAIN_MAX 3'h5
`define AGSCR_GAIN_DELAY_TICKS 5'h18
`define AGSCR_PULSE_CYC 4'h4
`define AGSCR_CRC_POLY 16'h8005
`endif

// ==== include/agscr_pkg.sv ====
// shared types of the gain/status/config slice
package agscr_pkg;
   typedef logic [4:0] agscr_addr_t;
   typedef logic [23:0] agscr_word_t;
   typedef enum logic [1:0] {
      AGSCR_RD_HOLD = 2'h0,
      AGSCR_RD_GROUP = 2'h1,
      AGSCR_RD_TYPE = 2'h2,
      AGSCR_RD_MAP = 2'h3
   } agscr_rdpol_e;
endpackage

// ==== include/agscr_if.sv ====
// carrier between the register core, the address counter and the ready pin logic
`timescale 1ns/100ps
interface agscr_if;
   import agscr_pkg::*;
   logic load;
   agscr_addr_t load_addr;
   logic rd_step;
   logic wr_step;
   agscr_rdpol_e rd_pol;
   logic wr_inc;
   agscr_addr_t addr;
   logic gain_cal;
   logic merge;
   logic idle_drive;
   logic int_hold;
   logic [5:0] ch_ready;
   logic pin_out;
   logic pin_oe_n;
   modport ctr(input load, load_addr, rd_step, wr_step, rd_pol, wr_inc, output addr);
   modport pin(input gain_cal, merge, idle_drive, int_hold, output ch_ready, pin_out, pin_oe_n);
   modport core(output load, load_addr, rd_step, wr_step, rd_pol, wr_inc, gain_cal, merge, idle_drive,
                int_hold, input addr, ch_ready, pin_out, pin_oe_n);
endinterface

// ==== core/agscr_addr_ctr.sv ====
// register address counter with read and write increment policies
`timescale 1ns/100ps
`include "agscr_cfg.svh"
module agscr_addr_ctr (
   input wire logic mclk,
   input wire logic reset,
   agscr_if.ctr bus
);
   import agscr_pkg::*;

   agscr_addr_t addr_q;
   agscr_addr_t addr_d;

   // step inside [lo,hi], back to lo past the top
   function automatic agscr_addr_t wrap_inc(agscr_addr_t a, agscr_addr_t lo, agscr_addr_t hi);
      return (a >= hi || a < lo) ? lo : agscr_addr_t'(a + 5'h01);
   endfunction

   // window bounds for group and type looping
   wire agscr_addr_t grp_lo = bus.addr & ~`AGSCR_GROUP_MASK;
   wire agscr_addr_t grp_hi = bus.addr | `AGSCR_GROUP_MASK;
   wire in_type0 = bus.addr <= `AGSCR_A_TYPE0_HI;
   wire agscr_addr_t type_lo = in_type0 ? `AGSCR_A_MAP_LO : `AGSCR_A_TYPE1_LO;
   wire agscr_addr_t type_hi = in_type0 ? `AGSCR_A_TYPE0_HI : `AGSCR_A_MAP_HI;
   wire agscr_addr_t rd_next = (bus.rd_pol == AGSCR_RD_MAP) ? wrap_inc(bus.addr, `AGSCR_A_MAP_LO, `AGSCR_A_MAP_HI) :
                               (bus.rd_pol == AGSCR_RD_TYPE) ? wrap_inc(bus.addr, type_lo, type_hi) :
                               (bus.rd_pol == AGSCR_RD_GROUP) ? wrap_inc(bus.addr, grp_lo, grp_hi) :
                               bus.addr;
   wire agscr_addr_t wr_next = bus.wr_inc ? wrap_inc(bus.addr, `AGSCR_A_WR_LO, `AGSCR_A_MAP_HI) : bus.addr;
   assign addr_d = bus.load ? bus.load_addr : bus.rd_step ? rd_next : bus.wr_step ? wr_next : addr_q;
   assign bus.addr = addr_q;

   // load wins over stepping
   always_ff @(posedge mclk) begin
      if (reset) begin
         addr_q <= `AGSCR_A_MAP_LO;
      end else begin
         addr_q <= addr_d;
      end
   end
endmodule

// ==== core/agscr_ready_pin.sv ====
// per-channel ready delay, merged pulse and data ready pin driver
`timescale 1ns/100ps
`include "agscr_cfg.svh"
module agscr_ready_pin (
   input wire logic mclk,
   input wire logic reset,
   input wire logic [5:0] raw_ready,
   input wire logic modulator_digital_clock_tick,
   agscr_if.pin bus
);
   import agscr_pkg::*;

   logic [4:0] dly_q [6];
   logic [5:0] ch_ready_d;
   logic [5:0] ch_ready_q;
   logic [5:0] seen_q;
   logic [3:0] pulse_q;
   logic pin_out_q;
   logic pin_oe_n_q;

   // immediate ready, or end of the gain correction delay
   always_comb begin
      for (int i = 0; i < 6; i++) begin
         ch_ready_d[i] = (raw_ready[i] && !bus.gain_cal) || (modulator_digital_clock_tick && dly_q[i] == 5'h01);
      end
   end

   wire [5:0] seen_d = seen_q | ch_ready_q;
   wire fire = bus.merge ? (&seen_d) : (|ch_ready_q);

   // delay counters in modulator clock ticks
   always_ff @(posedge mclk) begin
      for (int i = 0; i < 6; i++) begin
         if (reset) begin
            dly_q[i] <= 5'h00;
         end else if (raw_ready[i] && bus.gain_cal) begin
            dly_q[i] <= `AGSCR_GAIN_DELAY_TICKS;
         end else if (modulator_digital_clock_tick && dly_q[i] != 5'h00) begin
            dly_q[i] <= dly_q[i] - 5'h01;
         end
      end
   end

   // pulse timing and pin level
   always_ff @(posedge mclk) begin
      if (reset) begin
         ch_ready_q <= 6'h00;
         seen_q <= 6'h00;
         pulse_q <= 4'h0;
         pin_out_q <= 1'b1;
         pin_oe_n_q <= 1'b1;
      end else begin
         ch_ready_q <= ch_ready_d;
         seen_q <= (bus.merge && !fire) ? seen_d : 6'h00;
         pulse_q <= fire ? `AGSCR_PULSE_CYC : (pulse_q != 4'h0) ? pulse_q - 4'h1 : 4'h0;
         pin_out_q <= !(bus.int_hold || pulse_q != 4'h0);
         pin_oe_n_q <= !(bus.int_hold || pulse_q != 4'h0 || bus.idle_drive);
      end
   end

   assign bus.ch_ready = ch_ready_q;
   assign bus.pin_out = pin_out_q;
   assign bus.pin_oe_n = pin_oe_n_q;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);

   idle_float_a: assert property ((pulse_q == 4'h0 && !bus.int_hold && !bus.idle_drive) |=> pin_oe_n_q)
      else $error("ready pin not floating while idle");
   merge_hold_a: assert property ((bus.merge && seen_q == 6'h00 && ch_ready_q != 6'h3F && pulse_q == 4'h0)
      |=> pulse_q == 4'h0)
      else $error("merged pulse fired before all channels");
   gain_delay_a: assert property ((raw_ready[0] && bus.gain_cal) |=> dly_q[0] == `AGSCR_GAIN_DELAY_TICKS)
      else $error("gain correction delay not loaded");
endmodule

// ==== core/agscr_regs.sv ====
// gain, status/communication and configuration register slice of the front end
`timescale 1ns/100ps
`include "agscr_cfg.svh"
// Operation
// - gain codes 0..5 give 1..32, rest unity
// - read address policy: map, type, group, hold
// - write address auto-increments or holds
// - idle ready pin high or floating
// - ready pulses merged or per channel
// - checksum sent 16 or 32 bits
// - output data width and padding select
// - communication checksum appended when enabled
// - map mismatch holds ready pin low
// - checksum still computed without interrupt
// - ready flags low when ready, reset on read
// - offset correction enable, no added delay
// - gain correction delays ready by 24 ticks
// - dithering strength select, reset maximum
// - bias current scale select
// - analog clock prescaler divide 1,2,4,8
// - password unlocks, clears checksum and interrupt
module agscr_regs (
   input wire logic mclk,
   input wire logic reset,
   input wire logic addr_load,
   input wire agscr_pkg::agscr_addr_t addr_load_value,
   input wire logic write_strobe,
   input wire agscr_pkg::agscr_word_t write_data,
   input wire logic read_strobe,
   output agscr_pkg::agscr_word_t read_data,
   output logic read_valid,
   output agscr_pkg::agscr_addr_t current_addr,
   input wire logic [5:0] raw_ready,
   input wire logic modulator_digital_clock_tick,
   output logic data_ready_n_pin_out,
   output logic data_ready_n_pin_oe_n,
   output logic [17:0] channel_gain_log2,
   output logic comm_checksum_enable,
   output logic comm_checksum_wide,
   output logic [1:0] output_width_code,
   output logic offset_correction_enable,
   output logic gain_correction_enable,
   output logic [1:0] noise_spreading_level,
   output logic [1:0] bias_current_select,
   output logic analog_master_clock_en,
   output logic [15:0] map_checksum_value,
   output logic map_checksum_error
);
   import agscr_pkg::*;

   agscr_if bus ();

   agscr_word_t gain_q;
   agscr_word_t stat_q;
   agscr_word_t cfg_q;
   logic [5:0] flags_q;
   logic [5:0] flags_d;
   logic [7:0] lock_q;
   logic [15:0] crc_ref_q;
   logic [15:0] crc_q;
   logic crc_err_q;
   agscr_word_t rdata_q;
   logic rvalid_q;
   logic [17:0] gain_log2_q;
   logic [17:0] gain_log2_d;
   logic [2:0] pre_cnt_q;
   logic analog_master_clock_en_q;

   // merge written bits under a writable mask
   function automatic agscr_word_t masked_write(agscr_word_t old, agscr_word_t nw, agscr_word_t mask);
      return (old & ~mask) | (nw & mask);
   endfunction

   // reserved gain codes fall back to unity
   function automatic logic [2:0] gain_log2(logic [2:0] code);
      return (code > `AGSCR_GAIN_MAX) ? 3'h0 : code;
   endfunction

   // checksum over the stored configuration words
   function automatic logic [15:0] map_crc(logic [71:0] msg);
      logic [15:0] c;
      c = 16'h0000;
      for (int i = 71; i >= 0; i--) begin
         c = (c[15] ^ msg[i]) ? ((c << 1) ^ `AGSCR_CRC_POLY) : (c << 1);
      end
      return c;
   endfunction

   // address counter and ready pin
   agscr_addr_ctr u_addr_ctr (
      .mclk(mclk),
      .reset(reset),
      .bus(bus.ctr)
   );

   agscr_ready_pin u_ready_pin (
      .mclk(mclk),
      .reset(reset),
      .raw_ready(raw_ready),
      .modulator_digital_clock_tick(modulator_digital_clock_tick),
      .bus(bus.pin)
   );

   // access decode
   wire unlocked = lock_q == `AGSCR_LOCK_PW;
   wire hit_gain = bus.addr == `AGSCR_A_GAIN;
   wire hit_stat = bus.addr == `AGSCR_A_STAT;
   wire hit_cfg = bus.addr == `AGSCR_A_CFG;
   wire hit_lock = bus.addr == `AGSCR_A_LOCK;
   wire wr_gain = write_strobe && hit_gain && unlocked;
   wire wr_stat = write_strobe && hit_stat && unlocked;
   wire wr_cfg = write_strobe && hit_cfg && unlocked;
   wire wr_lock = write_strobe && hit_lock;
   wire rd_stat = read_strobe && hit_stat;
   wire [7:0] lock_wcode = write_data[`AGSCR_LK_CODE];

   // read selection, unimplemented and unmapped bits read zero
   wire agscr_word_t rd_word = hit_gain ? (gain_q & `AGSCR_GAIN_WMASK) :
                               hit_stat ? {stat_q[`AGSCR_ST_HI], flags_q} :
                               hit_cfg ? (cfg_q & `AGSCR_CFG_WMASK) :
                               hit_lock ? {lock_q, crc_q} :
                               24'h000000;

   // checksum source and live value
   wire [71:0] crc_msg = {gain_q, stat_q[23:12], 12'h000, cfg_q};
   wire [15:0] crc_calc = map_crc(crc_msg);

   // flags: ready clears to zero, status read restores, ready wins
   assign flags_d = (flags_q | {6{rd_stat}}) & ~bus.ch_ready;

   // counter and pin control
   assign bus.load = addr_load;
   assign bus.load_addr = addr_load_value;
   assign bus.rd_step = read_strobe;
   assign bus.wr_step = write_strobe;
   assign bus.rd_pol = agscr_rdpol_e'(stat_q[`AGSCR_ST_RDPOL]);
   assign bus.wr_inc = stat_q[`AGSCR_ST_WRINC];
   assign bus.gain_cal = cfg_q[`AGSCR_CF_GAINCAL];
   assign bus.merge = stat_q[`AGSCR_ST_MERGE];
   assign bus.idle_drive = stat_q[`AGSCR_ST_IDLE];
   assign bus.int_hold = crc_err_q && stat_q[`AGSCR_ST_MAPINT];

   // gain decode per channel
   always_comb begin
      gain_log2_d = 18'h00000;
      for (int i = 0; i < 6; i++) begin
         gain_log2_d[i*3 +: 3] = gain_log2(gain_q[i*3 +: 3]);
      end
   end

   // prescaler terminal count: 0, 1, 3 or 7
   wire [2:0] pre_last = 3'((4'h1 << cfg_q[`AGSCR_CF_PRE]) - 4'h1);
   wire pre_wrap = pre_cnt_q >= pre_last;

   // register writes; reserved status bits are stored as written
   always_ff @(posedge mclk) begin
      if (reset) begin
         gain_q <= `AGSCR_GAIN_RST;
         stat_q <= `AGSCR_STAT_RST;
         cfg_q <= `AGSCR_CFG_RST;
         lock_q <= `AGSCR_LOCK_PW;
      end else begin
         if (wr_gain) gain_q <= masked_write(gain_q, write_data, `AGSCR_GAIN_WMASK);
         if (wr_stat) stat_q <= masked_write(stat_q, write_data, `AGSCR_STAT_WMASK);
         if (wr_cfg) cfg_q <= masked_write(cfg_q, write_data, `AGSCR_CFG_WMASK);
         if (wr_lock) lock_q <= lock_wcode;
      end
   end

   // ready flags
   always_ff @(posedge mclk) begin
      if (reset) begin
         flags_q <= `AGSCR_FLAGS_RST;
      end else begin
         flags_q <= flags_d;
      end
   end

   // map checksum: reference taken at lock, cleared while unlocked
   always_ff @(posedge mclk) begin
      if (reset) begin
         crc_ref_q <= 16'h0000;
         crc_q <= 16'h0000;
         crc_err_q <= 1'b0;
      end else begin
         if (wr_lock && unlocked && lock_wcode != `AGSCR_LOCK_PW) crc_ref_q <= crc_calc;
         crc_q <= unlocked ? 16'h0000 : crc_calc;
         crc_err_q <= unlocked ? 1'b0 : (crc_err_q || crc_calc != crc_ref_q);
      end
   end

   // read data capture
   always_ff @(posedge mclk) begin
      if (reset) begin
         rdata_q <= 24'h000000;
         rvalid_q <= 1'b0;
      end else begin
         rvalid_q <= read_strobe;
         if (read_strobe) rdata_q <= rd_word;
      end
   end

   // gain output and analog clock enable
   always_ff @(posedge mclk) begin
      if (reset) begin
         gain_log2_q <= 18'h00000;
         pre_cnt_q <= 3'h0;
         analog_master_clock_en_q <= 1'b0;
      end else begin
         gain_log2_q <= gain_log2_d;
         pre_cnt_q <= pre_wrap ? 3'h0 : pre_cnt_q + 3'h1;
         analog_master_clock_en_q <= pre_wrap;
      end
   end

   // outputs
   assign read_data = rdata_q;
   assign read_valid = rvalid_q;
   assign current_addr = bus.addr;
   assign data_ready_n_pin_out = bus.pin_out;
   assign data_ready_n_pin_oe_n = bus.pin_oe_n;
   assign channel_gain_log2 = gain_log2_q;
   assign comm_checksum_enable = stat_q[`AGSCR_ST_CRCEN];
   assign comm_checksum_wide = stat_q[`AGSCR_ST_CRCW];
   assign output_width_code = stat_q[`AGSCR_ST_DWIDTH];
   assign offset_correction_enable = cfg_q[`AGSCR_CF_OFFCAL];
   assign gain_correction_enable = cfg_q[`AGSCR_CF_GAINCAL];
   assign noise_spreading_level = cfg_q[`AGSCR_CF_NOISE_SPREADING_LEVEL];
   assign bias_current_select = cfg_q[`AGSCR_CF_BIAS];
   assign analog_master_clock_en = analog_master_clock_en_q;
   assign map_checksum_value = crc_q;
   assign map_checksum_error = crc_err_q;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);

   sequence pw_write_s;
      wr_lock && lock_wcode == `AGSCR_LOCK_PW;
   endsequence

   sequence cleared_s;
      !crc_err_q && crc_q == 16'h0000;
   endsequence

   gain_reserved_a: assert property ((gain_q[2:0] > `AGSCR_GAIN_MAX) |=> channel_gain_log2[2:0] == 3'h0)
      else $error("reserved gain code not unity");
   gain_code_a: assert property ((gain_q[5:3] <= `AGSCR_GAIN_MAX)
      |=> channel_gain_log2[5:3] == $past(gain_q[5:3]))
      else $error("gain code not passed through");
   read_hold_a: assert property ((read_strobe && !addr_load && stat_q[`AGSCR_ST_RDPOL] == 2'h0)
      |=> current_addr == $past(current_addr))
      else $error("address moved in hold read mode");
   write_hold_a: assert property ((write_strobe && !read_strobe && !addr_load && !stat_q[`AGSCR_ST_WRINC])
      |=> current_addr == $past(current_addr))
      else $error("address moved in single write mode");
   flag_restore_a: assert property ((rd_stat && bus.ch_ready == 6'h00) |=> flags_q == `AGSCR_FLAGS_RST)
      else $error("status read did not restore flags");
   flag_setwins_a: assert property (bus.ch_ready[0] |=> !flags_q[0])
      else $error("ready event lost");
   lock_clear_a: assert property (pw_write_s |=> ##1 cleared_s)
      else $error("password did not clear checksum");
   int_pin_a: assert property ((crc_err_q && stat_q[`AGSCR_ST_MAPINT])
      |=> (!data_ready_n_pin_out && !data_ready_n_pin_oe_n))
      else $error("checksum interrupt not on ready pin");
   locked_write_a: assert property ((write_strobe && hit_cfg && !unlocked) |=> $stable(cfg_q))
      else $error("write taken while locked");
   locked_gain_a: assert property ((write_strobe && hit_gain && !unlocked) |=> $stable(gain_q))
      else $error("gain write taken while locked");
   flag_readonly_a: assert property ((wr_stat && !rd_stat && bus.ch_ready == 6'h00)
      |=> flags_q == $past(flags_q))
      else $error("ready flags written");
   unmapped_zero_a: assert property ((read_strobe && !hit_gain && !hit_stat && !hit_cfg && !hit_lock)
      |=> read_data == 24'h000000)
      else $error("unmapped read not zero");

   // pulse followed by two more cycles with the divide-by-8 setting kept
   sequence div8_run_s;
      (cfg_q[`AGSCR_CF_PRE] == 2'h3 && analog_master_clock_en_q) ##1 (cfg_q[`AGSCR_CF_PRE] == 2'h3) [*2];
   endsequence

   presc_div8_a: assert property (div8_run_s |=> !analog_master_clock_en_q && !$past(analog_master_clock_en_q) && !$past(analog_master_clock_en_q, 2))
      else $error("prescaler period wrong");
endmodule

// ==== testbench/agscr_host.sv ====
// host model driving the register port of the slice
`timescale 1ns/100ps
`include "agscr_cfg.svh"
module agscr_host (
   input wire logic mclk,
   input wire agscr_pkg::agscr_word_t read_data,
   input wire logic read_valid,
   output logic addr_load,
   output agscr_pkg::agscr_addr_t addr_load_value,
   output logic write_strobe,
   output agscr_pkg::agscr_word_t write_data,
   output logic read_strobe
);
   import agscr_pkg::*;
   // idle port levels from time zero
   initial begin
      addr_load = 1'b0;
      addr_load_value = 5'h00;
      write_strobe = 1'b0;
      write_data = 24'h000000;
      read_strobe = 1'b0;
   end
   // address load, held up to its sampling edge
   task automatic load(input agscr_addr_t a);
      @(posedge mclk);
      #1 addr_load = 1'b1;
      addr_load_value = a;
      @(posedge mclk);
      #1 addr_load = 1'b0;
      addr_load_value = ~a; // stale address no longer meaningful
   endtask
   // write one word at address a
   task automatic wr(input agscr_addr_t a, input agscr_word_t d);
      load(a);
      @(posedge mclk);
      #1 write_strobe = 1'b1;
      write_data = (a == `AGSCR_A_STAT) ? (d & 24'hFFCFFF) : d; // reserved bits sent as zero
      @(posedge mclk);
      #1 write_strobe = 1'b0;
      write_data = ~write_data;
   endtask
   // read one word at address a, answer taken one cycle after the strobe
   task automatic rd(input agscr_addr_t a, output agscr_word_t d, output logic v);
      load(a);
      @(posedge mclk);
      #1 read_strobe = 1'b1;
      @(posedge mclk);
      #1 read_strobe = 1'b0;
      d = read_data;
      v = read_valid;
   endtask
endmodule

// ==== testbench/agscr_regs_tb.sv ====
// self-checking bench of the gain/status/config register slice
`timescale 1ns/100ps
`include "agscr_cfg.svh"
module agscr_regs_tb;
   import agscr_pkg::*;
   typedef struct {agscr_addr_t a; agscr_word_t w; agscr_word_t r; logic [17:0] g;} agscr_row_s;
   logic mclk = 1'b0;
   logic reset = 1'b1;
   logic [5:0] raw_ready = 6'h00;
   logic modulator_digital_clock_tick = 1'b0;
   logic addr_load, write_strobe, read_strobe, read_valid, rv;
   logic data_ready_n_pin_out, data_ready_n_pin_oe_n, comm_checksum_enable, comm_checksum_wide;
   logic offset_correction_enable, gain_correction_enable, analog_master_clock_en, map_checksum_error;
   logic [1:0] output_width_code, noise_spreading_level, bias_current_select;
   logic [17:0] channel_gain_log2;
   logic [15:0] map_checksum_value;
   agscr_addr_t addr_load_value, current_addr;
   agscr_word_t write_data, read_data, rdat;
   int errors = 0;
   int checks = 0;
   int n, t, l;
   agscr_word_t rst_v [3] = '{24'h000000, 24'hA9003F, 24'h386050};
   agscr_row_s rows [6] = '{'{5'h0B, 24'h02C688, 24'h02C688, 18'h2C688}, '{5'h0B, 24'hFFFFFF, 24'h03FFFF, 18'h0},
      '{5'h0D, 24'hFFFFFF, 24'hFFE0FF, 18'h0}, '{5'h0D, 24'h000000, 24'h000000, 18'h0},
      '{5'h0C, 24'h000000, 24'h00003F, 18'h0}, '{5'h1E, 24'h123456, 24'h000000, 18'h0}};
   logic [1:0] pols [5] = '{2'h3, 2'h2, 2'h2, 2'h1, 2'h0};
   agscr_addr_t starts [5] = '{5'h1F, 5'h07, 5'h1F, 5'h0F, 5'h0D};
   agscr_addr_t nexts [5] = '{5'h00, 5'h00, 5'h08, 5'h0C, 5'h0D};

   agscr_regs i_agscr_regs (.mclk, .reset, .addr_load, .addr_load_value, .write_strobe, .write_data,
      .read_strobe, .read_data, .read_valid, .current_addr, .raw_ready, .modulator_digital_clock_tick, .data_ready_n_pin_out,
      .data_ready_n_pin_oe_n, .channel_gain_log2, .comm_checksum_enable, .comm_checksum_wide,
      .output_width_code, .offset_correction_enable, .gain_correction_enable, .noise_spreading_level,
      .bias_current_select, .analog_master_clock_en, .map_checksum_value, .map_checksum_error);
   agscr_host i_agscr_host (.mclk, .read_data, .read_valid, .addr_load, .addr_load_value, .write_strobe,
      .write_data, .read_strobe);

   // clock and a modulator tick every fourth cycle
   always #5 mclk = ~mclk;
   always begin
      repeat (3) @(posedge mclk);
      #1 modulator_digital_clock_tick = 1'b1;
      @(posedge mclk);
      #1 modulator_digital_clock_tick = 1'b0;
   end

   // compare and count
   task automatic check(input logic [23:0] seen, input logic [23:0] exp, input string msg);
      checks++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected at %0t: %s seen %h expected %h", $time, msg, seen, exp);
      end
   endtask
   task automatic stop_test;
      $display("errors %0d checks %0d", errors, checks);
      if (errors == 0 && checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // one-cycle converter ready pulse
   task automatic pulse(input logic [5:0] ch);
      @(posedge mclk);
      #1 raw_ready = ch;
      @(posedge mclk);
      #1 raw_ready = 6'h00;
   endtask
   // ticks until the pin is driven low, then its low width
   task automatic watch(input int lim, output int ticks, output int low);
      ticks = 0;
      low = 0;
      for (int i = 0; i < lim && low == 0; i++) begin
         @(posedge mclk);
         ticks += (modulator_digital_clock_tick === 1'b1);
         #1;
         if (data_ready_n_pin_out === 1'b0 && data_ready_n_pin_oe_n === 1'b0) begin
            while (data_ready_n_pin_out === 1'b0 && low < 20) begin
               low++;
               @(posedge mclk);
               #1;
            end
         end
      end
   endtask

   // hang guard
   initial begin
      #100000;
      errors++;
      $display("unexpected at %0t: watchdog", $time);
      stop_test;
   end

   initial begin
      repeat (4) @(posedge mclk);
      #1 reset = 1'b0;
      check(24'(data_ready_n_pin_oe_n), 24'h1, "idle float");
      foreach (rst_v[k]) begin
         i_agscr_host.rd(5'(k + 11), rdat, rv);
         check(rdat, rst_v[k], "reset value");
      end
      // readback table
      foreach (rows[k]) begin
         i_agscr_host.wr(rows[k].a, rows[k].w);
         i_agscr_host.rd(rows[k].a, rdat, rv);
         check(rdat, rows[k].r, "readback");
         check(24'(rv), 24'h1, "valid");
         if (rows[k].a == `AGSCR_A_GAIN) begin
            check(24'(channel_gain_log2), 24'(rows[k].g), "gain");
         end
      end
      // read address policies together with format bits
      for (int k = 0; k < 5; k++) begin
         i_agscr_host.wr(`AGSCR_A_STAT, {pols[k], 1'b1, 2'b00, k[0], k[1:0], k[1], 15'h0000});
         i_agscr_host.rd(starts[k], rdat, rv);
         check(24'(current_addr), 24'(nexts[k]), "rd step");
         check(24'({comm_checksum_wide, output_width_code, comm_checksum_enable}),
            24'({k[0], k[1:0], k[1]}), "format");
      end
      // per channel pulse, floating idle, flags restored by status read
      i_agscr_host.wr(`AGSCR_A_STAT, 24'h200000);
      pulse(6'h01);
      watch(20, t, l);
      check(24'(l), 24'(`AGSCR_PULSE_CYC), "pulse width");
      check(24'(data_ready_n_pin_oe_n), 24'h1, "float");
      i_agscr_host.rd(`AGSCR_A_STAT, rdat, rv);
      check(rdat, 24'h20003E, "flag ready");
      i_agscr_host.rd(`AGSCR_A_STAT, rdat, rv);
      check(rdat, 24'h20003F, "flag cleared");
      // driven idle and merged pulse
      i_agscr_host.wr(`AGSCR_A_STAT, 24'h380000);
      @(posedge mclk);
      #1 check(24'({data_ready_n_pin_out, data_ready_n_pin_oe_n}), 24'h2, "driven high");
      pulse(6'h1F);
      watch(12, t, l);
      check(24'(l), 24'h0, "merge wait");
      pulse(6'h20);
      watch(12, t, l);
      check(24'(l), 24'(`AGSCR_PULSE_CYC), "merge fire");
      // gain correction delays the pulse by 24 ticks
      i_agscr_host.wr(`AGSCR_A_STAT, 24'h200000);
      i_agscr_host.wr(`AGSCR_A_CFG, 24'h786050);
      @(posedge mclk iff modulator_digital_clock_tick === 1'b1);
      pulse(6'h01);
      watch(200, t, l);
      check(24'(t), 24'd24, "cal delay");
      check(24'(l), 24'(`AGSCR_PULSE_CYC), "cal pulse");
      // configuration fields and prescaler rate
      for (int k = 0; k < 4; k++) begin
         i_agscr_host.wr(`AGSCR_A_CFG, {k[0], 1'b0, k[1:0], ~k[1:0], k[1:0], 16'h6050});
         repeat (8) @(posedge mclk);
         n = 0;
         repeat (16) begin
            @(negedge mclk);
            n += (analog_master_clock_en === 1'b1);
         end
         check(24'(n), 24'(16 >> k), "prescale");
         check(24'({offset_correction_enable, gain_correction_enable, noise_spreading_level,
            bias_current_select}), 24'({k[0], 1'b0, k[1:0], ~k[1:0]}), "config");
      end
      // write stepping, lock and unlock
      i_agscr_host.wr(`AGSCR_A_STAT, 24'h200000);
      i_agscr_host.wr(`AGSCR_A_LOCK, 24'h000000);
      check(24'(current_addr), 24'h08, "wr wrap");
      i_agscr_host.wr(`AGSCR_A_GAIN, 24'h000001);
      i_agscr_host.rd(`AGSCR_A_GAIN, rdat, rv);
      check(rdat, 24'h03FFFF, "locked");
      i_agscr_host.wr(`AGSCR_A_CFG, 24'h000000);
      i_agscr_host.rd(`AGSCR_A_CFG, rdat, rv);
      check(rdat, 24'hB36050, "cfg locked");
      i_agscr_host.rd(`AGSCR_A_LOCK, rdat, rv);
      check(24'(rdat[23:16]), 24'h00, "lock field");
      i_agscr_host.wr(`AGSCR_A_LOCK, 24'hA50000);
      @(posedge mclk);
      #1 check(24'({map_checksum_error, map_checksum_value}), 24'h0, "unlock clears");
      i_agscr_host.wr(`AGSCR_A_STAT, 24'h000000);
      i_agscr_host.wr(`AGSCR_A_CFG, 24'h386050);
      check(24'(current_addr), 24'h0D, "wr hold");
      // second reset in mid-run
      reset = 1'b1;
      repeat (4) @(posedge mclk);
      #1 reset = 1'b0;
      check(24'(data_ready_n_pin_oe_n), 24'h1, "reset float");
      i_agscr_host.rd(`AGSCR_A_STAT, rdat, rv);
      check(rdat, 24'hA9003F, "reset status");
      stop_test;
   end
endmodule
